// file: src/dblu_alu_if.sv
// carrier between the field sequencer and the digit logic unit
`timescale 1ns/1ns
`default_nettype none
interface dblu_alu_if;
	logic start;
	dblu_pkg::dblu_lop_e lop;
	logic [dblu_pkg::DIG_W-1:0] p_dig;
	logic [dblu_pkg::DIG_W-1:0] q_dig;
	logic [dblu_pkg::DIG_W-1:0] res_dig;
	logic res_valid;
	modport core (output start, output lop, output p_dig, output q_dig, input res_dig, input res_valid);
	modport alu (input start, input lop, input p_dig, input q_dig, output res_dig, output res_valid);
endinterface : dblu_alu_if
`default_nettype wire

// file: src/dblu_digit_alu.sv
// one-digit octal logic with flag keeping and parity regeneration
`timescale 1ns/1ns
`default_nettype none
module dblu_digit_alu (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	dblu_alu_if.alu alu_bus
);
	typedef struct packed {
		logic [dblu_pkg::DIG_W-1:0] res;
		logic valid;
	} dblu_alu_state_s;

	dblu_alu_state_s s_reg;
	dblu_alu_state_s s_next;

	always_comb begin
		logic [2:0] bits;
		bits = 3'h0;
		s_next = s_reg;
		s_next.valid = 1'b0;
		if (alu_bus.start) begin
			// parity and 8 bits of both inputs never enter the logic
			unique case (alu_bus.lop)
				dblu_pkg::DBLU_LOP_OR: bits = alu_bus.p_dig[2:0] | alu_bus.q_dig[2:0];
				dblu_pkg::DBLU_LOP_AND: bits = alu_bus.p_dig[2:0] & alu_bus.q_dig[2:0];
				dblu_pkg::DBLU_LOP_XOR: bits = alu_bus.p_dig[2:0] ^ alu_bus.q_dig[2:0];
				default: bits = 3'h0;
			endcase
			// P flag kept, 8 bit dropped, parity rebuilt
			s_next.res = dblu_pkg::dblu_with_parity({alu_bus.p_dig[dblu_pkg::BIT_F], 1'b0, bits});
			s_next.valid = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_reg <= '0;
		end else if (ce_i) begin
			s_reg <= s_next;
		end
	end

	assign alu_bus.res_dig = s_reg.res;
	assign alu_bus.res_valid = s_reg.valid;
endmodule : dblu_digit_alu
`default_nettype wire

// file: src/dblu_pkg.sv
// constants, types and helpers shared by the digit bit logic unit
package dblu_pkg;
	// opcodes, decimal 90..93 and 95
	localparam logic [6:0] OP_BRANCH_ANY_BIT = 7'h5A;
	localparam logic [6:0] OP_BRANCH_MASK_MATCH = 7'h5B;
	localparam logic [6:0] OP_FIELD_OR = 7'h5C;
	localparam logic [6:0] OP_FIELD_AND = 7'h5D;
	localparam logic [6:0] OP_FIELD_XOR = 7'h5F;

	// storage digit layout: parity, flag, 8, 4, 2, 1
	localparam int DIG_W = 6;
	localparam int BIT_C = 5;
	localparam int BIT_F = 4;
	localparam int BIT_8 = 3;

	// index of the last digit of a five-digit indirect address
	localparam logic [2:0] IND_LAST = 3'h4;
	localparam logic [13:0] BCD_W3 = 14'h03E8;
	localparam logic [13:0] BCD_W2 = 14'h0064;
	localparam logic [13:0] BCD_W1 = 14'h000A;

	// register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_MASK = 8'h08;
	localparam logic [7:0] REG_STATE = 8'h0C;
	localparam logic [7:0] REG_BINARY = 8'h10;
	localparam logic [7:0] REG_OCTAL = 8'h14;
	localparam logic [31:0] UNMAPPED_VALUE = 32'h00000000;

	// status / mask bits
	localparam int EV_DONE = 0;
	localparam int EV_BRANCH = 1;
	localparam int EV_ZERO = 2;
	localparam int EV_W = 3;

	// reset values
	localparam logic CTRL_IND_EN_RST = 1'h1;
	localparam logic [EV_W-1:0] MASK_RST = 3'h0;

	// binary read conversion
	localparam int BIN_W = 12;
	localparam int OCT_DIGITS = 4;

	typedef enum logic [1:0] {
		DBLU_LOP_OR = 2'h0,
		DBLU_LOP_AND = 2'h1,
		DBLU_LOP_XOR = 2'h2
	} dblu_lop_e;

	// adds the parity bit so the stored digit has an odd bit count
	function automatic logic [DIG_W-1:0] dblu_with_parity(input logic [DIG_W-2:0] d);
		dblu_with_parity = {~^d, d};
	endfunction : dblu_with_parity
endpackage : dblu_pkg

// file: src/dblu_top.sv
// digit bit-test branches and digit-serial octal field logic
`timescale 1ns/1ns
`default_nettype none
module dblu_top #(
	parameter int ADDR_W = 20
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// instruction from the sequencer
	input wire logic instr_valid_i,
	input wire logic [6:0] instr_op_i,
	input wire logic [ADDR_W-1:0] instr_p_i,
	input wire logic instr_p_ind_i,
	input wire logic [ADDR_W-1:0] instr_q_i,
	input wire logic [15:0] instr_q_bcd_i,
	input wire logic instr_q_ind_i,
	input wire logic [dblu_pkg::DIG_W-1:0] instr_q7_i,
	output logic busy_o,
	output logic done_o,
	output logic branch_o,
	output logic [ADDR_W-1:0] branch_addr_o,
	output logic eq_zero_o,
	// core storage
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [ADDR_W-1:0] mem_addr_o,
	output logic [dblu_pkg::DIG_W-1:0] mem_wdata_o,
	input wire logic mem_ack_i,
	input wire logic [dblu_pkg::DIG_W-1:0] mem_rdata_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	output logic irq_o
);
	////////////////////////////////////////////////////////////////////////////
	// types and state

	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_INDIRECT = 8'h02,
		ST_TEST = 8'h04,
		ST_READ_Q = 8'h08,
		ST_READ_P = 8'h10,
		ST_CALC = 8'h20,
		ST_WRITE_P = 8'h40,
		ST_FINISH = 8'h80
	} dblu_state_e;

	typedef struct packed {
		dblu_state_e st;
		logic [6:0] op;
		logic [ADDR_W-1:0] p_adr;
		logic [ADDR_W-1:0] q_adr;
		logic [dblu_pkg::DIG_W-1:0] q7;
		logic [ADDR_W-1:0] acc;
		logic [2:0] cnt;
		logic ind_q;
		logic q_pending;
		logic [dblu_pkg::DIG_W-1:0] q_dig;
		logic last;
		logic nonzero;
		logic hit;
		logic mreq;
		logic mwe;
		logic [ADDR_W-1:0] madr;
		logic [dblu_pkg::DIG_W-1:0] mwd;
		logic busy;
		logic done;
		logic brn;
		logic [ADDR_W-1:0] baddr;
		logic eqz;
		logic ind_en;
		logic [dblu_pkg::EV_W-1:0] stat;
		logic [dblu_pkg::EV_W-1:0] mask;
		logic [dblu_pkg::BIN_W-1:0] bin;
		logic [31:0] rdata;
		logic irq;
	} dblu_state_s;

	dblu_state_s s_reg;
	dblu_state_s s_next;

	dblu_alu_if alu_bus ();

	dblu_digit_alu u_alu (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.alu_bus(alu_bus.alu)
	);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// four decimal digits give 0..9999, so nothing higher is reachable directly
	function automatic logic [ADDR_W-1:0] bcd4_to_addr(input logic [15:0] b);
		logic [13:0] v;
		v = 14'(b[15:12]) * dblu_pkg::BCD_W3 + 14'(b[11:8]) * dblu_pkg::BCD_W2
			+ 14'(b[7:4]) * dblu_pkg::BCD_W1 + 14'(b[3:0]);
		bcd4_to_addr = ADDR_W'(v);
	endfunction : bcd4_to_addr

	logic is_branch;
	logic is_field;
	logic [dblu_pkg::EV_W-1:0] events;
	logic [dblu_pkg::DIG_W*dblu_pkg::OCT_DIGITS-1:0] octal_view;

	assign is_branch = (instr_op_i == dblu_pkg::OP_BRANCH_ANY_BIT) || (instr_op_i == dblu_pkg::OP_BRANCH_MASK_MATCH);
	assign is_field = (instr_op_i == dblu_pkg::OP_FIELD_OR) || (instr_op_i == dblu_pkg::OP_FIELD_AND)
		|| (instr_op_i == dblu_pkg::OP_FIELD_XOR);

	// binary data split in three-bit groups, each one stored octal digit
	genvar gi;
	generate
		for (gi = 0; gi < dblu_pkg::OCT_DIGITS; gi++) begin : g_octal
			assign octal_view[gi*dblu_pkg::DIG_W +: dblu_pkg::DIG_W] =
				dblu_pkg::dblu_with_parity({2'h0, s_reg.bin[gi*3 +: 3]});
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [ADDR_W-1:0] next_acc;
		logic [dblu_pkg::DIG_W-1:0] d;
		logic any_hit;
		logic mask_hit;
		next_acc = '0;
		d = mem_rdata_i;
		any_hit = 1'b0;
		mask_hit = 1'b0;
		s_next = s_reg;
		s_next.done = 1'b0;
		s_next.brn = 1'b0;
		s_next.rdata = dblu_pkg::UNMAPPED_VALUE;
		events = '0;
		alu_bus.start = 1'b0;
		alu_bus.lop = dblu_pkg::DBLU_LOP_OR;
		alu_bus.p_dig = mem_rdata_i;
		alu_bus.q_dig = s_reg.q_dig;
		unique case (s_reg.op)
			dblu_pkg::OP_FIELD_AND: alu_bus.lop = dblu_pkg::DBLU_LOP_AND;
			dblu_pkg::OP_FIELD_XOR: alu_bus.lop = dblu_pkg::DBLU_LOP_XOR;
			default: alu_bus.lop = dblu_pkg::DBLU_LOP_OR;
		endcase

		unique case (s_reg.st)
			ST_IDLE: begin
				if (instr_valid_i && (is_branch || is_field)) begin
					s_next.op = instr_op_i;
					s_next.p_adr = instr_p_i;
					s_next.q7 = instr_q7_i;
					s_next.nonzero = 1'b0;
					s_next.busy = 1'b1;
					s_next.mreq = 1'b1;
					s_next.mwe = 1'b0;
					if (is_branch) begin
						s_next.q_adr = bcd4_to_addr(instr_q_bcd_i);
						s_next.q_pending = instr_q_ind_i && s_reg.ind_en;
						s_next.acc = '0;
						s_next.cnt = '0;
						if (instr_p_ind_i && s_reg.ind_en) begin
							s_next.ind_q = 1'b0;
							s_next.madr = instr_p_i - ADDR_W'(dblu_pkg::IND_LAST);
							s_next.st = ST_INDIRECT;
						end else if (instr_q_ind_i && s_reg.ind_en) begin
							s_next.ind_q = 1'b1;
							s_next.q_pending = 1'b0;
							s_next.madr = bcd4_to_addr(instr_q_bcd_i) - ADDR_W'(dblu_pkg::IND_LAST);
							s_next.st = ST_INDIRECT;
						end else begin
							s_next.madr = bcd4_to_addr(instr_q_bcd_i);
							s_next.st = ST_TEST;
						end
					end else begin
						// field starts at both units digits
						s_next.q_adr = instr_q_i;
						s_next.madr = instr_q_i;
						s_next.st = ST_READ_Q;
					end
				end
			end

			ST_INDIRECT: begin
				// five digits high to low; a flag on the units digit chains again
				if (mem_ack_i) begin
					next_acc = ADDR_W'(s_reg.acc * ADDR_W'(4'hA)) + ADDR_W'(d[3:0]);
					s_next.acc = next_acc;
					s_next.madr = s_reg.madr + ADDR_W'(1'h1);
					s_next.cnt = s_reg.cnt + 3'h1;
					if (s_reg.cnt == dblu_pkg::IND_LAST) begin
						s_next.acc = '0;
						s_next.cnt = '0;
						if (d[dblu_pkg::BIT_F]) begin
							s_next.madr = next_acc - ADDR_W'(dblu_pkg::IND_LAST);
						end else if (!s_reg.ind_q) begin
							s_next.p_adr = next_acc;
							if (s_reg.q_pending) begin
								s_next.ind_q = 1'b1;
								s_next.q_pending = 1'b0;
								s_next.madr = s_reg.q_adr - ADDR_W'(dblu_pkg::IND_LAST);
							end else begin
								s_next.madr = s_reg.q_adr;
								s_next.st = ST_TEST;
							end
						end else begin
							s_next.q_adr = next_acc;
							s_next.madr = next_acc;
							s_next.st = ST_TEST;
						end
					end
				end
			end

			ST_TEST: begin
				if (mem_ack_i) begin
					// parity never compared
					any_hit = |(s_reg.q7[dblu_pkg::BIT_F:0] & d[dblu_pkg::BIT_F:0]);
					mask_hit = ((s_reg.q7[dblu_pkg::BIT_8:0] & ~d[dblu_pkg::BIT_8:0]) == '0)
						&& (!s_reg.q7[dblu_pkg::BIT_F] || d[dblu_pkg::BIT_F]);
					s_next.hit = (s_reg.op == dblu_pkg::OP_BRANCH_ANY_BIT) ? any_hit : mask_hit;
					s_next.mreq = 1'b0;
					s_next.st = ST_FINISH;
				end
			end

			ST_READ_Q: begin
				if (mem_ack_i) begin
					s_next.q_dig = d;
					s_next.last = d[dblu_pkg::BIT_F];
					s_next.madr = s_reg.p_adr;
					s_next.st = ST_READ_P;
				end
			end

			ST_READ_P: begin
				if (mem_ack_i) begin
					alu_bus.start = 1'b1;
					s_next.mreq = 1'b0;
					s_next.st = ST_CALC;
				end
			end

			ST_CALC: begin
				if (alu_bus.res_valid) begin
					// only P is ever written
					s_next.mreq = 1'b1;
					s_next.mwe = 1'b1;
					s_next.madr = s_reg.p_adr;
					s_next.mwd = alu_bus.res_dig;
					s_next.nonzero = s_reg.nonzero || (|alu_bus.res_dig[2:0]);
					s_next.st = ST_WRITE_P;
				end
			end

			ST_WRITE_P: begin
				if (mem_ack_i) begin
					s_next.mwe = 1'b0;
					if (s_reg.last) begin
						s_next.mreq = 1'b0;
						s_next.st = ST_FINISH;
					end else begin
						s_next.p_adr = s_reg.p_adr - ADDR_W'(1'h1);
						s_next.q_adr = s_reg.q_adr - ADDR_W'(1'h1);
						s_next.madr = s_reg.q_adr - ADDR_W'(1'h1);
						s_next.st = ST_READ_Q;
					end
				end
			end

			ST_FINISH: begin
				s_next.done = 1'b1;
				s_next.busy = 1'b0;
				s_next.baddr = s_reg.p_adr;
				events[dblu_pkg::EV_DONE] = 1'b1;
				if ((s_reg.op == dblu_pkg::OP_BRANCH_ANY_BIT) || (s_reg.op == dblu_pkg::OP_BRANCH_MASK_MATCH)) begin
					// branches touch no indicator
					s_next.brn = s_reg.hit;
					events[dblu_pkg::EV_BRANCH] = s_reg.hit;
				end else begin
					s_next.eqz = !s_reg.nonzero;
					events[dblu_pkg::EV_ZERO] = !s_reg.nonzero;
				end
				s_next.st = ST_IDLE;
			end

			default: begin
				s_next.st = ST_IDLE;
				s_next.mreq = 1'b0;
				s_next.mwe = 1'b0;
				s_next.busy = 1'b0;
			end
		endcase

		////////////////////////////////////////////////////////////////////////
		// register port; a new event wins over the clearing read

		if (reg_wr_i) begin
			unique case (reg_addr_i)
				dblu_pkg::REG_CTRL: s_next.ind_en = reg_wdata_i[0];
				dblu_pkg::REG_MASK: s_next.mask = reg_wdata_i[dblu_pkg::EV_W-1:0];
				dblu_pkg::REG_BINARY: s_next.bin = reg_wdata_i[dblu_pkg::BIN_W-1:0];
				default: s_next.ind_en = s_reg.ind_en;
			endcase
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				dblu_pkg::REG_CTRL: s_next.rdata = 32'(s_reg.ind_en);
				dblu_pkg::REG_STATUS: s_next.rdata = 32'(s_reg.stat);
				dblu_pkg::REG_MASK: s_next.rdata = 32'(s_reg.mask);
				dblu_pkg::REG_STATE: s_next.rdata = 32'({s_reg.st, s_reg.eqz, s_reg.busy});
				dblu_pkg::REG_BINARY: s_next.rdata = 32'(s_reg.bin);
				dblu_pkg::REG_OCTAL: s_next.rdata = 32'(octal_view);
				default: s_next.rdata = dblu_pkg::UNMAPPED_VALUE;
			endcase
		end
		s_next.stat = ((reg_rd_i && reg_addr_i == dblu_pkg::REG_STATUS) ? '0 : s_reg.stat) | events;
		s_next.irq = |(s_next.stat & s_reg.mask);
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_reg <= '0;
			s_reg.st <= ST_IDLE;
			s_reg.ind_en <= dblu_pkg::CTRL_IND_EN_RST;
			s_reg.mask <= dblu_pkg::MASK_RST;
		end else if (ce_i) begin
			s_reg <= s_next;
		end
	end

	assign busy_o = s_reg.busy;
	assign done_o = s_reg.done;
	assign branch_o = s_reg.brn;
	assign branch_addr_o = s_reg.baddr;
	assign eq_zero_o = s_reg.eqz;
	assign mem_req_o = s_reg.mreq;
	assign mem_we_o = s_reg.mwe;
	assign mem_addr_o = s_reg.madr;
	assign mem_wdata_o = s_reg.mwd;
	assign reg_rdata_o = s_reg.rdata;
	assign irq_o = s_reg.irq;
endmodule : dblu_top
`default_nettype wire

// file: tb/dblu_mem_model.sv
// core storage model answering after a settable delay
`timescale 1ns/1ns
`default_nettype none
module dblu_mem_model #(
	parameter int ADDR_W = 20,
	parameter int DEPTH = 20000
) (
	input wire logic clk_i,
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [5:0] wdata_i,
	input wire logic [3:0] lat_i,
	output logic ack_o,
	output logic [5:0] rdata_o
);
	logic [5:0] mem [DEPTH];
	logic [5:0] last = 6'h00;
	logic [3:0] cnt = 4'h0;
	assign ack_o = req_i && cnt == lat_i;
	// outside an answer the bus shows the inverse of the last digit, never a stale copy
	assign rdata_o = (ack_o && !we_i) ? mem[addr_i] : ~last;
	always @(posedge clk_i) begin
		if (ack_o) begin
			cnt <= 4'h0;
			last <= we_i ? wdata_i : mem[addr_i];
			if (we_i) mem[addr_i] <= wdata_i;
		end else if (req_i) begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule : dblu_mem_model
`default_nettype wire

// file: tb/dblu_props.sv
// port assertions for the digit bit logic unit
`timescale 1ns/1ns
`default_nettype none
module dblu_props #(
	parameter int ADDR_W = 20
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	input wire logic instr_valid_i,
	input wire logic [6:0] instr_op_i,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic branch_o,
	input wire logic eq_zero_o,
	input wire logic mem_req_o,
	input wire logic mem_we_o,
	input wire logic [ADDR_W-1:0] mem_addr_o,
	input wire logic mem_ack_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);
	////////////////////////////////////////////////////////////////
	wire logic take = ce_i && instr_valid_i && !busy_o;
	wire logic known = instr_op_i inside {dblu_pkg::OP_BRANCH_ANY_BIT, dblu_pkg::OP_BRANCH_MASK_MATCH,
		dblu_pkg::OP_FIELD_OR, dblu_pkg::OP_FIELD_AND, dblu_pkg::OP_FIELD_XOR};
	wire logic br_take = instr_op_i[6:1] == 6'h2D;
	// remembers the kind of the op in flight, kept until the next accept
	logic br_op;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			br_op <= 1'b0;
		end else if (take && known) begin
			br_op <= br_take;
		end
	end
	sequence s_take;
		take && known;
	endsequence
	sequence s_end;
		!busy_o ##1 !done_o;
	endsequence
	////////////////////////////////////////////////////////////////
	a_take_busy: assert property (s_take |=> busy_o)
		else $error("busy not raised after accept");
	a_done_pulse: assert property (done_o |-> s_end)
		else $error("done not a single pulse ending busy");
	a_op_bounded: assert property (s_take |-> ##[2:300] done_o)
		else $error("operation did not finish in time");
	a_branch_done: assert property (branch_o |-> done_o && br_op)
		else $error("branch outside a branch completion");
	a_req_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
		else $error("storage request changed before ack");
	a_br_nowrite: assert property (br_op && mem_req_o |-> !mem_we_o)
		else $error("branch wrote storage");
	a_br_eqz: assert property (br_op |-> $stable(eq_zero_o))
		else $error("branch changed equal zero");
	a_eqz_done: assert property (!done_o |-> $stable(eq_zero_o))
		else $error("equal zero moved outside completion");
	a_rd_idle: assert property (ce_i && !reg_rd_i |=> reg_rdata_o == 32'h00000000)
		else $error("read data not zero outside a read");
endmodule : dblu_props
`default_nettype wire

// file: tb/tb_dblu_top.sv
// self-checking bench for the digit bit logic unit
`timescale 1ns/1ns
`default_nettype none
module tb_dblu_top;
	localparam logic [6:0] BA = dblu_pkg::OP_BRANCH_ANY_BIT;
	localparam logic [6:0] BM = dblu_pkg::OP_BRANCH_MASK_MATCH;
	localparam logic [19:0] PD = {5'h09, 5'h01, 5'h12, 5'h07};
	localparam logic [19:0] QD = {5'h12, 5'h05, 5'h06, 5'h01};
	localparam logic [19:0] QZ = {5'h18, 5'h08, 5'h08, 5'h08};
	localparam logic [19:0] Q1 = {5'h05, 5'h05, 5'h06, 5'h11};
	localparam logic [19:0] BT [9] = '{{BA, 6'h01, 6'h04, 1'b0}, {BA, 6'h01, 6'h05, 1'b1}, {BA, 6'h20, 6'h20, 1'b0},
		{BA, 6'h18, 6'h10, 1'b1}, {BM, 6'h05, 6'h07, 1'b1}, {BM, 6'h05, 6'h04, 1'b0}, {BM, 6'h11, 6'h01, 1'b0},
		{BM, 6'h11, 6'h11, 1'b1}, {BM, 6'h01, 6'h11, 1'b1}};
	logic clk_i = 1'b0, arst_n_i = 1'b0, ce_i = 1'b1, instr_valid_i = 1'b0;
	logic [6:0] instr_op_i = 7'h00;
	logic [19:0] instr_p_i = 20'h00000, instr_q_i = 20'h00000;
	logic instr_p_ind_i = 1'b0, instr_q_ind_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic [15:0] instr_q_bcd_i = 16'h0000;
	logic [5:0] instr_q7_i = 6'h00;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h00000000;
	logic [3:0] lat = 4'h0;
	logic [19:0] frz;
	wire logic busy_o, done_o, branch_o, eq_zero_o, mem_req_o, mem_we_o, mem_ack_i, irq_o;
	wire logic [19:0] branch_addr_o, mem_addr_o;
	wire logic [5:0] mem_wdata_o, mem_rdata_i;
	wire logic [31:0] reg_rdata_o;
	int err_total = 0;
	int num_checks = 0;
	always #20 clk_i = ~clk_i;
	dblu_top #(.ADDR_W(20)) uut (.clk_i, .arst_n_i, .ce_i, .instr_valid_i, .instr_op_i, .instr_p_i, .instr_p_ind_i,
		.instr_q_i, .instr_q_bcd_i, .instr_q_ind_i, .instr_q7_i, .busy_o, .done_o, .branch_o, .branch_addr_o,
		.eq_zero_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i, .mem_rdata_i, .reg_addr_i,
		.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o);
	dblu_mem_model sm (.clk_i, .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
		.lat_i(lat), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
	////////////////////////////////////////////////////////////////
	function automatic logic [5:0] par(input logic [4:0] d);
		return {~^d, d};
	endfunction : par
	function automatic logic [2:0] f(input logic [6:0] o, input logic [2:0] p, input logic [2:0] q);
		if (o == dblu_pkg::OP_FIELD_OR) return p | q;
		if (o == dblu_pkg::OP_FIELD_AND) return p & q;
		return p ^ q;
	endfunction : f
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude
	task automatic rwr(input logic [7:0] a, input logic [31:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask : rwr
	task automatic rrd(input logic [7:0] a, input logic [31:0] e, input string n);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 chk(n, e, reg_rdata_o);
		@(posedge clk_i);
	endtask : rrd
	task automatic run(input logic [6:0] o);
		int n;
		n = 0;
		instr_op_i <= o;
		instr_valid_i <= 1'b1;
		@(posedge clk_i);
		instr_valid_i <= 1'b0;
		do begin
			@(posedge clk_i);
			#1 n++;
		end while (done_o !== 1'b1 && n < 400);
		chk("done", 1'b1, done_o);
	endtask : run
	task automatic fld(input logic [6:0] o, input logic [19:0] pd, input logic [19:0] qd, input int n);
		logic [2:0] r;
		logic z;
		z = 1'b1;
		for (int i = 0; i < 4; i++) begin
			sm.mem[1003 - i] = par(pd[i*5+:5]);
			sm.mem[2003 - i] = par(qd[i*5+:5]);
		end
		sm.mem[999] = 6'h15;
		instr_p_i <= 20'h003EB;
		instr_q_i <= 20'h007D3;
		run(o);
		for (int i = 0; i < 4; i++) begin
			r = f(o, pd[i*5+:3], qd[i*5+:3]);
			if (i < n) z &= (r == 3'h0);
			chk("p_digit", i < n ? par({pd[i*5+4], 1'b0, r}) : par(pd[i*5+:5]), sm.mem[1003 - i]);
			chk("q_digit", par(qd[i*5+:5]), sm.mem[2003 - i]);
		end
		chk("p_beyond", 6'h15, sm.mem[999]);
		chk("eq_zero", z, eq_zero_o);
		chk("field_branch", 1'b0, branch_o);
	endtask : fld
	task automatic br(input logic [19:0] e);
		logic z;
		z = eq_zero_o;
		sm.mem[9999] = e[6:1];
		instr_q_bcd_i <= 16'h9999;
		instr_q7_i <= e[12:7];
		instr_p_i <= 20'h00123;
		run(e[19:13]);
		chk("branch", e[0], branch_o);
		if (e[0]) chk("target", 20'h00123, branch_addr_o);
		chk("eq_hold", z, eq_zero_o);
		chk("tested_digit", e[6:1], sm.mem[9999]);
	endtask : br
	////////////////////////////////////////////////////////////////
	initial begin
		#2000000;
		err_total++;
		conclude();
	end
	initial begin
		repeat (3) @(posedge clk_i);
		arst_n_i <= 1'b1;
		@(posedge clk_i);
		rrd(dblu_pkg::REG_CTRL, 32'h00000001, "ctrl");
		rrd(dblu_pkg::REG_STATE, 32'h00000004, "state");
		rrd(dblu_pkg::REG_MASK, 32'h00000000, "mask");
		rwr(8'h20, 32'hFFFFFFFF);
		rrd(8'h20, 32'h00000000, "unmapped");
		rwr(dblu_pkg::REG_BINARY, 32'h0000055F);
		rrd(dblu_pkg::REG_OCTAL, {8'h00, par(5'h02), par(5'h05), par(5'h03), par(5'h07)}, "octal");
		rrd(dblu_pkg::REG_BINARY, 32'h0000055F, "binary");
		rwr(dblu_pkg::REG_MASK, 32'h00000001);
		instr_op_i <= 7'h5E;
		instr_valid_i <= 1'b1;
		@(posedge clk_i);
		instr_valid_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		#1 chk("busy_unknown", 1'b0, busy_o);
		fld(dblu_pkg::OP_FIELD_OR, PD, QD, 4);
		repeat (2) @(posedge clk_i);
		#1 chk("irq_set", 1'b1, irq_o);
		rrd(dblu_pkg::REG_STATUS, 32'h00000001, "status");
		rrd(dblu_pkg::REG_STATUS, 32'h00000000, "status_clear");
		#1 chk("irq_clear", 1'b0, irq_o);
		rwr(dblu_pkg::REG_MASK, 32'h00000002);
		// slow storage exercises the held request path
		lat <= 4'h2;
		fld(dblu_pkg::OP_FIELD_AND, PD, QD, 4);
		// a low clock enable must freeze the sequence in mid-field
		fork
			fld(dblu_pkg::OP_FIELD_XOR, PD, QD, 4);
			begin
				repeat (5) @(posedge clk_i);
				ce_i <= 1'b0;
				@(posedge clk_i);
				#1 frz = mem_addr_o;
				repeat (9) @(posedge clk_i);
				#1 chk("frozen_addr", frz, mem_addr_o);
				ce_i <= 1'b1;
			end
		join
		fld(dblu_pkg::OP_FIELD_AND, PD, QZ, 4);
		fld(dblu_pkg::OP_FIELD_OR, PD, Q1, 1);
		repeat (2) @(posedge clk_i);
		#1 chk("irq_masked", 1'b0, irq_o);
		lat <= 4'h1;
		foreach (BT[i]) br(BT[i]);
		for (int i = 0; i < 5; i++) begin
			sm.mem[596 + i] = par(5'(i + 1));
			sm.mem[696 + i] = (i == 2) ? par(5'h08) : par(5'h00);
		end
		sm.mem[12345] = par(5'h05);
		instr_q_bcd_i <= 16'h0600;
		instr_p_i <= 20'h002BC;
		instr_q7_i <= 6'h01;
		instr_p_ind_i <= 1'b1;
		instr_q_ind_i <= 1'b1;
		// indirection switched off: both addresses are used as they stand
		rwr(dblu_pkg::REG_CTRL, 32'h00000000);
		run(BA);
		chk("noind_branch", 1'b1, branch_o);
		chk("noind_target", 20'h002BC, branch_addr_o);
		rwr(dblu_pkg::REG_CTRL, 32'h00000001);
		rrd(dblu_pkg::REG_STATUS, 32'h00000007, "status_all");
		run(BA);
		chk("ind_branch", 1'b1, branch_o);
		chk("ind_target", 20'h00320, branch_addr_o);
		repeat (2) @(posedge clk_i);
		#1 chk("irq_branch", 1'b1, irq_o);
		conclude();
	end
endmodule : tb_dblu_top
bind dblu_top dblu_props #(.ADDR_W(ADDR_W)) u_props (.clk_i, .arst_n_i, .ce_i, .instr_valid_i, .instr_op_i,
	.busy_o, .done_o, .branch_o, .eq_zero_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_ack_i, .reg_rd_i,
	.reg_rdata_o);
`default_nettype wire
